// ===== src/rsc_config.sv
// Purpose: radio state machine config register with calibration scheduling
// Assumes: host writes over the serial config port, decoded to wr_en/addr
// Notes:   state machine and calibration engine live outside this block
`timescale 1ns/100ps

// Overview of operation
// - at schedule 00 calibration happens only on the host calibrate strobe.
// - at schedule 01 calibrate on every idle to rx, tx or synth-on entry.
// - at schedule 10 calibrate on every return from rx or tx to idle.
// - at schedule 11 calibrate on every fourth return to idle, counted.
// - chip ready goes low only after the ripple counter expired enough times.
// - timeout select 00..11 means 1, 16, 64 and 256 expirations.
module rsc_config (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  input  wire logic              wr_en,
  input  wire logic [7:0]        addr,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata,
  input  wire rsc_pkg::rsc_evt_t evt,
  input  wire logic              crystal_osc_stable,
  output logic                   cal_start,
  output logic                   chip_ready_n,
  output logic                   pin_ctrl_en,
  output logic                   crystal_keep_on
);
  // configuration register and its decoded access
  rsc_pkg::rsc_cfg_t cfg_q;
  rsc_pkg::rsc_cfg_t cfg_d;
  logic              wr_hit;
  logic              rd_hit;

  // returns to idle, counted for the every-fourth schedule
  logic [1:0]        ret_cnt_q;
  logic [1:0]        ret_cnt_d;
  logic              ret_fourth;

  // calibration triggers, one per source
  logic              cal_manual;
  logic              cal_sched;
  logic              cal_d;

  // power-up timeout and ready sequencing
  logic [8:0]        target;
  logic              expired;
  logic              ready_d;

  // ready sequencer states, binary codes fixed
  typedef enum logic [1:0] {
    PU_OFF   = 2'b00,
    PU_COUNT = 2'b01,
    PU_READY = 2'b10
  } rsc_pu_state_t;

  // sequencer state
  rsc_pu_state_t     pu_q;
  rsc_pu_state_t     pu_d;

  // address decode; ce gates the write so a frozen block ignores host writes
  assign wr_hit = ce && wr_en && (addr == rsc_pkg::REG_ADDR);
  assign rd_hit = (addr == rsc_pkg::REG_ADDR);

  // next register value, field by field; reserved bits never stored
  always_comb begin
    cfg_d = cfg_q;
    if (wr_hit) begin
      cfg_d.rsvd               = 2'b00;
      cfg_d.cal_schedule       =
        rsc_pkg::rsc_cal_t'(wdata[rsc_pkg::CAL_LSB +: 2]);
      cfg_d.powerup_expire_sel = wdata[rsc_pkg::PO_LSB +: 2];
      cfg_d.pin_ctrl_en        = wdata[rsc_pkg::PIN_BIT];
      cfg_d.crystal_keep_on    = wdata[rsc_pkg::XO_BIT];
    end
  end

  // register write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= rsc_pkg::rsc_cfg_t'(rsc_pkg::REG_RESET);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata = 8'h00;
    if (rd_hit) begin
      rdata = cfg_q;
    end
  end

  // runs in all schedules, never restarted on a mode change
  always_comb begin
    ret_cnt_d = ret_cnt_q;
    if (evt.active_to_idle) begin
      ret_cnt_d = ret_cnt_q + 2'h1;
    end
  end

  // the fourth return is the one seen while the count sits at its wrap
  assign ret_fourth = (ret_cnt_q == rsc_pkg::RET_WRAP);

  // returns to idle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ret_cnt_q <= 2'h0;
    end else if (ce) begin
      ret_cnt_q <= ret_cnt_d;
    end
  end

  // manual strobe calibrates in every schedule
  assign cal_manual = evt.calibrate_strobe;

  // automatic trigger per schedule
  always_comb begin
    cal_sched = 1'b0;
    case (cfg_q.cal_schedule)
      rsc_pkg::CAL_NEVER: begin
        cal_sched = 1'b0;
      end
      rsc_pkg::CAL_ENTER: begin
        cal_sched = evt.idle_to_active;
      end
      rsc_pkg::CAL_RETURN: begin
        cal_sched = evt.active_to_idle;
      end
      rsc_pkg::CAL_FOURTH: begin
        cal_sched = evt.active_to_idle && ret_fourth;
      end
      default: begin
        cal_sched = 1'b0;
      end
    endcase
  end

  // both sources merge into one request
  assign cal_d = cal_manual || cal_sched;

  // registered one-cycle calibration request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_start <= 1'b0;
    end else if (ce) begin
      cal_start <= cal_d;
    end
  end

  // expire count select, read live so a rewrite applies at once
  always_comb begin
    case (cfg_q.powerup_expire_sel)
      2'b00: begin
        target = rsc_pkg::EXP_SEL0;
      end
      2'b01: begin
        target = rsc_pkg::EXP_SEL1;
      end
      2'b10: begin
        target = rsc_pkg::EXP_SEL2;
      end
      default: begin
        target = rsc_pkg::EXP_SEL3;
      end
    endcase
  end

  // expirations of the six-bit counter while the crystal is stable
  rsc_ripple u_ripple (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .run     (crystal_osc_stable),
    .target  (target),
    .done    (expired)
  );

  // ready sequencer; a crystal drop always wins over a pending expiry
  always_comb begin
    pu_d = pu_q;
    case (pu_q)
      PU_OFF: begin
        if (crystal_osc_stable) begin
          pu_d = PU_COUNT;
        end
      end
      PU_COUNT: begin
        if (!crystal_osc_stable) begin
          pu_d = PU_OFF;
        end else if (expired) begin
          pu_d = PU_READY;
        end
      end
      PU_READY: begin
        if (!crystal_osc_stable) begin
          pu_d = PU_OFF;
        end
      end
      default: begin
        pu_d = PU_OFF;
      end
    endcase
  end

  // ready only in the ready state, so a lost crystal drops it at once
  assign ready_d = (pu_d == PU_READY);

  // sequencer state and registered active-low ready
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pu_q         <= PU_OFF;
      chip_ready_n <= 1'b1;
    end else if (ce) begin
      pu_q         <= pu_d;
      chip_ready_n <= ~ready_d;
    end
  end

  // control bits straight from the register flops
  assign pin_ctrl_en     = cfg_q.pin_ctrl_en;
  assign crystal_keep_on = cfg_q.crystal_keep_on;
endmodule

// ===== src/rsc_pkg.sv
// Purpose: constants and types for the radio state config register block
// Assumes: one clock, registers reached through a simple write/read port
// Notes:   field layout of the single config register
package rsc_pkg;
  localparam logic [7:0] REG_ADDR      = 8'h17;
  localparam logic [7:0] REG_RESET     = 8'h04;
  localparam int         CAL_LSB       = 4;
  localparam int         PO_LSB        = 2;
  localparam int         PIN_BIT       = 1;
  localparam int         XO_BIT        = 0;
  localparam logic [5:0] RIPPLE_MAX    = 6'h3F;
  localparam logic [8:0] EXP_SEL0      = 9'h001;
  localparam logic [8:0] EXP_SEL1      = 9'h010;
  localparam logic [8:0] EXP_SEL2      = 9'h040;
  localparam logic [8:0] EXP_SEL3      = 9'h100;
  localparam logic [1:0] RET_WRAP      = 2'h3;

  typedef enum logic [1:0] {
    CAL_NEVER  = 2'b00,
    CAL_ENTER  = 2'b01,
    CAL_RETURN = 2'b10,
    CAL_FOURTH = 2'b11
  } rsc_cal_t;

  typedef struct packed {
    logic [1:0] rsvd;
    rsc_cal_t   cal_schedule;
    logic [1:0] powerup_expire_sel;
    logic       pin_ctrl_en;
    logic       crystal_keep_on;
  } rsc_cfg_t;

  // radio state transition events from the state machine
  typedef struct packed {
    logic idle_to_active;
    logic active_to_idle;
    logic calibrate_strobe;
  } rsc_evt_t;
endpackage

// ===== src/rsc_ripple.sv
// Purpose: six-bit ripple counter that counts its own expirations
// Assumes: run is held high while counting
// Notes:   done stays high until run drops
`timescale 1ns/100ps
module rsc_ripple (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [8:0] target,
  output logic            done
);
  logic [5:0] ripple_q;
  logic [8:0] expire_q;

  // count expirations of the six-bit counter
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ripple_q <= 6'h00;
      expire_q <= 9'h000;
      done     <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        ripple_q <= 6'h00;
        expire_q <= 9'h000;
        done     <= 1'b0;
      end else if (!done) begin
        ripple_q <= ripple_q + 6'h01;
        if (ripple_q == rsc_pkg::RIPPLE_MAX) begin
          expire_q <= expire_q + 9'h001;
          // at-or-past, so lowering the select mid-wait cannot hang
          if (expire_q + 9'h001 >= target) done <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== tb/rsc_config_props.sv
// Purpose: checker for rsc_config
// Assumes: mode is seen through rdata while addr is 0x17
// Notes:   up_q saturates, only small counts matter
`timescale 1ns/100ps
module rsc_config_props (
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic              ce,
  input wire logic              wr_en,
  input wire logic [7:0]        addr,
  input wire logic [7:0]        wdata,
  input wire logic [7:0]        rdata,
  input wire rsc_pkg::rsc_evt_t evt,
  input wire logic              crystal_osc_stable,
  input wire logic              cal_start,
  input wire logic              chip_ready_n,
  input wire logic              pin_ctrl_en,
  input wire logic              crystal_keep_on
);
  logic [1:0] ret_q; // returns to idle
  logic [9:0] up_q;  // enabled cycles with crystal stable
  wire        hit = addr == rsc_pkg::REG_ADDR;
  // return count runs from reset, as the design's does
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) ret_q <= 2'h0;
    else if (ce && evt.active_to_idle) ret_q <= ret_q + 2'h1;
  end
  // restarts whenever the crystal drops; frozen with ce like the design
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) up_q <= 10'h000;
    else if (ce && !crystal_osc_stable) up_q <= 10'h000;
    else if (ce && up_q != 10'h3FF) up_q <= up_q + 10'h001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  strobe_cal_a: assert property (ce && evt.calibrate_strobe |=> cal_start)
    else $error("no cal on strobe");
  never_cal_a: assert property (ce && hit && rdata[5:4] == 2'h0
    && !evt.calibrate_strobe |=> !cal_start) else $error("cal in mode 0");
  entry_cal_a: assert property (ce && hit && rdata[5:4] == 2'h1
    && evt.idle_to_active |=> cal_start) else $error("no cal on entry");
  return_cal_a: assert property (ce && hit && rdata[5:4] == 2'h2
    && evt.active_to_idle |=> cal_start) else $error("no cal on return");
  fourth_cal_a: assert property (ce && hit && rdata[5:4] == 2'h3
    && evt == 3'h2 |=> cal_start == ($past(ret_q) == 2'h3))
    else $error("fourth return wrong");
  early_ready_a: assert property (up_q != 10'h000 && up_q < 10'h040
    |-> chip_ready_n) else $error("ready too early");
  short_ready_a: assert property (hit && rdata[3:2] == 2'h0
    && up_q == 10'h041 |-> !chip_ready_n) else $error("ready late");
  long_wait_a: assert property (hit && rdata[3:2] != 2'h0
    && up_q != 10'h000 && up_q < 10'h3FF |-> chip_ready_n)
    else $error("long wait too short");
  frozen_out_a: assert property (!ce |=> $stable(cal_start)
    && $stable(chip_ready_n)) else $error("outputs moved while frozen");
  ctrl_bits_a: assert property (hit |->
    {pin_ctrl_en, crystal_keep_on} == rdata[1:0]) else $error("bits");
endmodule
bind rsc_config rsc_config_props i_props (
  .sys_clk            (sys_clk),
  .rst_b              (rst_b),
  .ce                 (ce),
  .wr_en              (wr_en),
  .addr               (addr),
  .wdata              (wdata),
  .rdata              (rdata),
  .evt                (evt),
  .crystal_osc_stable (crystal_osc_stable),
  .cal_start          (cal_start),
  .chip_ready_n       (chip_ready_n),
  .pin_ctrl_en        (pin_ctrl_en),
  .crystal_keep_on    (crystal_keep_on)
);

// ===== tb/rsc_config_test.sv
// Purpose: self-checking bench for rsc_config
// Assumes: ce held high except in the freeze scenario
// Notes:   ready delay allowed a few cycles past N*64
`timescale 1ns/100ps
module rsc_config_test;
  logic              sys_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              ce = 1'b1;
  logic              crystal_osc_stable = 1'b0;
  rsc_pkg::rsc_evt_t evt = 3'h0;
  logic              wr_en, cal_start, chip_ready_n;
  logic              pin_ctrl_en, crystal_keep_on, c;
  logic [7:0]        addr, wdata, rdata;
  int                errors = 0, num_checks = 0, cyc = 0, n;
  int                tbl[4] = '{1, 16, 64, 256};
  always #10 sys_clk = ~sys_clk;
  rsc_host   i_rsc_host (
    .sys_clk (sys_clk),
    .wr_en   (wr_en),
    .addr    (addr),
    .wdata   (wdata)
  );
  rsc_config i_rsc_config (
    .sys_clk            (sys_clk),
    .rst_b              (rst_b),
    .ce                 (ce),
    .wr_en              (wr_en),
    .addr               (addr),
    .wdata              (wdata),
    .rdata              (rdata),
    .evt                (evt),
    .crystal_osc_stable (crystal_osc_stable),
    .cal_start          (cal_start),
    .chip_ready_n       (chip_ready_n),
    .pin_ctrl_en        (pin_ctrl_en),
    .crystal_keep_on    (crystal_keep_on)
  );
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // cal_start is looked at one cycle after the event edge
  task automatic pulse(input logic [2:0] e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= 3'h0;
    #1 c = cal_start;
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      i_rsc_host.put(8'h17, {2'h3, m[1:0], 2'h1, m[1:0]});
      #1 chk(rdata === {2'h0, m[1:0], 2'h1, m[1:0]}, "write");
      chk({pin_ctrl_en, crystal_keep_on} === m[1:0], "bits");
      pulse(3'h4);
      chk(c === (m == 1), "entry");
      n = 0;
      for (int k = 0; k < 4; k++) begin
        pulse(3'h2);
        if (c === 1'b1) n++;
      end
      chk(n == (m == 2 ? 4 : int'(m == 3)), "returns");
      pulse(3'h1);
      chk(c === 1'b1, "strobe");
    end
  endtask
  task automatic t_ready;
    for (int s = 0; s < 4; s++) begin
      i_rsc_host.put(8'h17, {4'h0, s[1:0], 2'h0});
      crystal_osc_stable <= 1'b1;
      n = 0;
      while (chip_ready_n !== 1'b0 && n < 20000) begin
        @(posedge sys_clk);
        #1 n++;
      end
      chk(n >= tbl[s] * 64 && n <= tbl[s] * 64 + 4, "delay");
      @(posedge sys_clk);
      crystal_osc_stable <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 chk(chip_ready_n === 1'b1, "not ready");
    end
  endtask
  // ce low must freeze the register and the calibration request
  task automatic t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    i_rsc_host.put(8'h17, 8'h33);
    pulse(3'h1);
    chk(rdata === 8'h0C && c === 1'b0, "freeze");
    @(posedge sys_clk);
    ce <= 1'b1;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk(rdata === 8'h04 && crystal_keep_on === 1'b0, "reset");
    chk(chip_ready_n === 1'b1 && cal_start === 1'b0, "reset out");
    i_rsc_host.put(8'h18, 8'hFF);
    #1 chk(rdata === 8'h00 && pin_ctrl_en === 1'b0, "unmapped");
    t_modes;
    t_ready;
    t_freeze;
    test_done;
  end
endmodule

// ===== tb/rsc_host.sv
// Purpose: host model writing the config port
// Assumes: address held after a write, data released inverted
// Notes:   bench picks the advised setting values
`timescale 1ns/100ps
module rsc_host (
  input  wire logic       sys_clk,
  output logic            wr_en,
  output logic [7:0]      addr,
  output logic [7:0]      wdata
);
  initial {wr_en, addr, wdata} = {1'b0, 8'h17, 8'h00};
  // strobe held up to its sampling edge
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {wr_en, addr, wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    {wr_en, wdata} <= {1'b0, ~d};
  endtask
endmodule
